//--- src/rbs_pkg.sv
// package for the reset and boot select block
package rbs_pkg;
    localparam int RBS_RELEASE_CYCLES = 32;
    localparam int RBS_CNT_W          = 16;
    localparam int RBS_POR_CYCLES     = 4;
    localparam logic RBS_PIN_TIED     = 1'b0;

    typedef struct packed {
        logic resetPin;
        logic bootSelect;
        logic extMemory;
    } rbs_pullup_type;

    typedef enum logic [1:0] {
        RBS_BOOT_INTERNAL = 2'h0,
        RBS_BOOT_EXTERNAL = 2'h1
    } rbs_boot_type;

    typedef struct packed {
        rbs_boot_type mode;
        logic         flashSecure;
        logic         extMemory;
    } rbs_bootcfg_type;
endpackage : rbs_pkg

//--- src/rbs_reset_boot.sv
// chip reset sequencer and boot mode capture
// Notes on behaviour
// - external low reset holds device in reset
// - release synchronous, after fixed clock count
// - power-on reset asserts independent of pin
// - reset-pin disable bit turns pull-up off
// - reset output mirrors internal chip reset
// - boot select pin is tied off; never boots off-chip
// - secure flash forbids off-chip boot
// - internal boot always; select input is tied off, so no input decides
// - boot and memory inputs always read zero
`timescale 1ns/1ns
module rbs_reset_boot
    import rbs_pkg::*;
#(
    parameter int RELEASE_CYCLES = RBS_RELEASE_CYCLES
) (
    input  wire logic                clk,
    input  wire logic                rst_b,
    input  wire logic                resetPin_b,
    input  wire logic                porActive,
    input  wire logic                flashSecure,
    input  wire logic                offchip_boot_select,
    input  wire logic                ext_memory_mode_pin,
    input  wire rbs_pkg::rbs_pullup_type pullup_disable_register,
    output logic                     chipReset_b,
    output logic                     reset_state_output_b,
    output rbs_pkg::rbs_bootcfg_type bootCfg,
    output rbs_pkg::rbs_pullup_type  pullupEnable
);
    import rbs_pkg::*;

    typedef enum logic [1:0] {ST_POR, ST_HOLD, ST_COUNT, ST_RUN} rbs_state_type;

    localparam logic [RBS_CNT_W-1:0] RELEASE_LAST = RBS_CNT_W'(RELEASE_CYCLES - 1);
    localparam logic [RBS_CNT_W-1:0] POR_LAST     = RBS_CNT_W'(RBS_POR_CYCLES - 1);

    rbs_state_type         state_r, state_nxt;
    logic [RBS_CNT_W-1:0]  cnt_r, cnt_nxt;
    logic                  chipReset_r, chipReset_nxt;
    logic                  reset_state_output_r, reset_state_output_nxt;
    rbs_bootcfg_type       boot_r, boot_nxt;
    rbs_pullup_type        pu_r, pu_nxt;
    logic                  pinLevel;
    logic                  porSync;
    logic                  anyReset;
    logic                  bootSel;
    logic                  memMode;

    // pin reaches logic through filter; a stuck-low pin keeps device reset
    rbs_sync3 #(.RESET_VAL(1'b0)) u_pin_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (resetPin_b),
        .dout  (pinLevel)
    );

    rbs_sync3 #(.RESET_VAL(1'b1)) u_por_sync (
        .clk   (clk),
        .rst_b (rst_b),
        .din   (porActive),
        .dout  (porSync)
    );

    // package ties both strap inputs low; pin ports are ignored on purpose
    assign bootSel  = RBS_PIN_TIED & offchip_boot_select;
    assign memMode  = RBS_PIN_TIED & ext_memory_mode_pin;
    assign anyReset = !pinLevel || porSync;

    always_comb begin
        state_nxt     = state_r;
        cnt_nxt       = cnt_r;
        chipReset_nxt = chipReset_r;
        boot_nxt      = boot_r;
        unique case (state_r)
            ST_POR: begin
                // power-on reset runs its own count, pin not needed
                chipReset_nxt = 1'b0;
                if (cnt_r == POR_LAST) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_HOLD: begin
                chipReset_nxt = 1'b0;
                cnt_nxt       = '0;
                if (!anyReset) begin
                    state_nxt = ST_COUNT;
                end
            end
            ST_COUNT: begin
                if (anyReset) begin
                    state_nxt = ST_HOLD;
                    cnt_nxt   = '0;
                end else if (cnt_r == RELEASE_LAST) begin
                    state_nxt     = ST_RUN;
                    chipReset_nxt = 1'b1;
                    // boot mode latched only at release; secure flash forces internal
                    boot_nxt.flashSecure = flashSecure;
                    boot_nxt.extMemory   = memMode;
                    boot_nxt.mode = (bootSel && !flashSecure) ? RBS_BOOT_EXTERNAL
                                                              : RBS_BOOT_INTERNAL;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            ST_RUN: begin
                if (anyReset) begin
                    state_nxt     = ST_HOLD;
                    chipReset_nxt = 1'b0;
                    cnt_nxt       = '0;
                end
            end
        endcase
        reset_state_output_nxt = chipReset_nxt;
        pu_nxt.resetPin   = !pullup_disable_register.resetPin;
        pu_nxt.bootSelect = !pullup_disable_register.bootSelect;
        pu_nxt.extMemory  = !pullup_disable_register.extMemory;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state_r     <= ST_POR;
            cnt_r       <= '0;
            chipReset_r <= 1'b0;
            reset_state_output_r      <= 1'b0;
            boot_r      <= '{mode: RBS_BOOT_INTERNAL, flashSecure: 1'b0, extMemory: 1'b0};
            pu_r        <= '1;
        end else begin
            state_r     <= state_nxt;
            cnt_r       <= cnt_nxt;
            chipReset_r <= chipReset_nxt;
            reset_state_output_r      <= reset_state_output_nxt;
            boot_r      <= boot_nxt;
            pu_r        <= pu_nxt;
        end
    end

    assign chipReset_b          = chipReset_r;
    assign reset_state_output_b = reset_state_output_r;
    assign bootCfg              = boot_r;
    assign pullupEnable         = pu_r;

    // assertions
    sequence s_released;
        $rose(chipReset_r);
    endsequence

    a_reset_held_low: assert property (@(posedge clk) disable iff (!rst_b)
        (anyReset && state_r == ST_HOLD) |=> !chipReset_r)
        else $error("chip reset released while a source is active");

    a_release_after_count: assert property (@(posedge clk) disable iff (!rst_b)
        s_released |-> $past(cnt_r) == RELEASE_LAST && $past(state_r) == ST_COUNT)
        else $error("reset released without full count");

    a_por_holds: assert property (@(posedge clk) disable iff (!rst_b)
        state_r == ST_POR |-> !chipReset_r)
        else $error("reset released during power-on phase");

    a_pullup_follows: assert property (@(posedge clk) disable iff (!rst_b)
        pullup_disable_register.resetPin |=> !pu_r.resetPin)
        else $error("reset pin pull-up not switched off");

    a_output_mirror: assert property (@(posedge clk) disable iff (!rst_b)
        reset_state_output_r == chipReset_r)
        else $error("reset output differs from chip reset");

    a_secure_internal: assert property (@(posedge clk) disable iff (!rst_b)
        boot_r.flashSecure |-> boot_r.mode == RBS_BOOT_INTERNAL)
        else $error("external boot with secure flash");

    a_boot_latched: assert property (@(posedge clk) disable iff (!rst_b)
        s_released |-> boot_r.mode == RBS_BOOT_INTERNAL)
        else $error("boot mode not internal with tied-low select");

    a_ties_zero: assert property (@(posedge clk) disable iff (!rst_b)
        !bootSel && !memMode ##1 !boot_r.extMemory)
        else $error("strap input seen as high");

    a_reassert_fast: assert property (@(posedge clk) disable iff (!rst_b)
        (state_r == ST_RUN && anyReset) |=> !chipReset_r ##1 !reset_state_output_r)
        else $error("reset not reasserted at once");
endmodule : rbs_reset_boot

//--- src/rbs_sync3.sv
// three-stage synchroniser with agreement filter
`timescale 1ns/1ns
module rbs_sync3 #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic din,
    output logic      dout
);
    logic [2:0] stage_r;
    logic [2:0] stage_nxt;
    logic       out_r;
    logic       out_nxt;

    always_comb begin
        stage_nxt = {stage_r[1:0], din};
        out_nxt   = (stage_r[1] == stage_r[2]) ? stage_r[2] : out_r;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            stage_r <= {3{RESET_VAL}};
            out_r   <= RESET_VAL;
        end else begin
            stage_r <= stage_nxt;
            out_r   <= out_nxt;
        end
    end

    assign dout = out_r;
endmodule : rbs_sync3

//--- verif/rbs_board_model.sv
// board reset source and debug controller model
`timescale 1ns/1ns
module rbs_board_model (
    input  wire logic clk,
    output logic      resetPin_b,
    output logic      porActive,
    output logic      testReset_b
);
    // reset pin has a pull-up, so idle is high
    initial begin
        resetPin_b  = 1'b1;
        porActive   = 1'b1;
        testReset_b = 1'b0;
    end

    task automatic hold_reset(input int n, input bit full);
        @(negedge clk);
        resetPin_b  = 1'b0;
        testReset_b = full ? 1'b0 : 1'b1;
        repeat (n) @(negedge clk);
        resetPin_b  = 1'b1;
        testReset_b = 1'b1;
    endtask : hold_reset

    task automatic power_up();
        porActive = 1'b0;
    endtask : power_up
endmodule : rbs_board_model

//--- verif/testbench.sv
// self-checking bench for the reset and boot select block
`timescale 1ns/1ns
module testbench;
    import rbs_pkg::*;
    localparam int REL = 8;
    logic            clk, rst_b, resetPin_b, porActive, testReset_b;
    logic            flashSecure, bootSel, memMode, chipReset_b, rstOut_b;
    rbs_pullup_type  pud, pue;
    rbs_bootcfg_type cfg;
    int              mismatches = 0;
    int              n_tests = 0;

    rbs_board_model i_board (.clk(clk), .resetPin_b(resetPin_b), .porActive(porActive), .testReset_b(testReset_b));
    rbs_reset_boot #(.RELEASE_CYCLES(REL)) i_dut (
        .clk(clk), .rst_b(rst_b), .resetPin_b(resetPin_b), .porActive(porActive),
        .flashSecure(flashSecure), .offchip_boot_select(bootSel), .ext_memory_mode_pin(memMode),
        .pullup_disable_register(pud), .chipReset_b(chipReset_b), .reset_state_output_b(rstOut_b),
        .bootCfg(cfg), .pullupEnable(pue));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input string what, input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : print_verdict

    // bounded wait for the internal reset to lift
    task automatic wait_release(output int n);
        n = 0;
        while (chipReset_b !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        if (chipReset_b !== 1'b1) begin
            check("release timeout", 4'h0, 4'h1);
            print_verdict();
        end
    endtask : wait_release

    task automatic power_on();
        int n;
        repeat (20) @(negedge clk);
        check("reset during power-on", {chipReset_b, rstOut_b}, 4'h0);
        i_board.power_up();
        wait_release(n);
        check("power-on release delay", (n > REL && n <= REL + 8), 4'h1);
        check("reset output", rstOut_b, 4'h1);
    endtask : power_on

    // strap pins are held high on purpose: they must be ignored
    task automatic pin_reset(input bit full, input logic fs);
        int n;
        flashSecure = fs;
        i_board.hold_reset(10, full);
        check("reset held by pin", {chipReset_b, rstOut_b}, 4'h0);
        check("test reset released", testReset_b, 4'h1);
        wait_release(n);
        check("pin release delay", (n > REL && n <= REL + 8), 4'h1);
        check("reset output", rstOut_b, 4'h1);
        check("boot config", cfg, {RBS_BOOT_INTERNAL, fs, 1'b0});
    endtask : pin_reset

    task automatic pullups();
        for (int i = 0; i < 8; i++) begin
            pud = rbs_pullup_type'(i[2:0]);
            @(negedge clk);
            check("pull-up enable", pue, {1'b0, ~i[2:0]});
        end
    endtask : pullups

    initial begin
        rst_b       = 1'b0;
        flashSecure = 1'b0;
        bootSel     = 1'b1;
        memMode     = 1'b1;
        pud         = 3'h0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        power_on();
        pin_reset(1'b1, 1'b0);
        pin_reset(1'b0, 1'b1);
        pullups();
        print_verdict();
    end
endmodule : testbench
